// ==== common/qpmii_map.vh ====
// Constants for one MII data port of the quad 10/100 transceiver.
// Assumes the core clock runs at QPMII_CLK_PERIOD_NS.
`ifndef QPMII_MAP_VH
`define QPMII_MAP_VH

`define QPMII_CLK_PERIOD_NS 10
`define QPMII_FAST_PERIOD_NS 40
`define QPMII_SLOW_PERIOD_NS 400
`define QPMII_FAST_HALF_CYC (`QPMII_FAST_PERIOD_NS / (2 * `QPMII_CLK_PERIOD_NS))
`define QPMII_SLOW_HALF_CYC (`QPMII_SLOW_PERIOD_NS / (2 * `QPMII_CLK_PERIOD_NS))
`define QPMII_CAP_DELAY 4
`define QPMII_WORD_W 6
`define QPMII_FIFO_DEPTH 8
`define QPMII_FIFO_AW 3
`define QPMII_F_DATA_LSB 0
`define QPMII_F_DATA_MSB 3
`define QPMII_F_EN 4
`define QPMII_F_ER 5
`define QPMII_IDLE_NIBBLE 4'h0
`define QPMII_RESET_NIBBLE 4'h0

`endif

// ==== sim/qpmii_mac.sv ====
// Behavioural MAC transmit side for one MII port.
// Assumes tx_clk comes from the port; it is sampled with clk.
`timescale 1ns/1ps
module qpmii_mac
(
    input wire clk,
    input wire reset,
    input wire tx_clk,
    input wire adv,
    input wire [3:0] n_data,
    input wire n_en,
    input wire n_er,
    output logic [3:0] tx_data,
    output logic tx_en,
    output logic tx_er
);
logic last_q;
logic [3:0] junk_q;
always @(posedge clk)
begin
    last_q <= tx_clk;
    junk_q <= reset ? 4'h0 : junk_q + 4'h1;
    if (reset)
    begin
        tx_en <= 1'h0;
        tx_er <= 1'h0;
        tx_data <= 4'h0;
    end
    // Change only just after the edge opposite to capture, so pins stand a full half period
    else if (last_q != tx_clk && tx_clk == adv)
    begin
        tx_en <= n_en;
        tx_er <= n_er;
        // Data means nothing while idle, so keep it moving to expose leaks
        tx_data <= (n_en | n_er) ? n_data : junk_q;
    end
end
endmodule

// ==== sim/qpmii_port_bench.sv ====
// Self-checking bench for one MII data port with a MAC model.
// Assumes a 100 MHz core clock; ce is held high throughout.
`timescale 1ns/1ps
module qpmii_port_bench;
logic clk, reset, ce, speed_100, adv, line_ready, rx_sym_valid, rx_sym_bad, pll_locked, n_en, n_er, tx_en, tx_er;
logic [3:0] rx_sym_data, n_data, tx_data;
wire tx_clk, line_valid, line_tx_on, line_halt, rx_clk, rx_dv, rx_er;
wire [3:0] line_data, rx_data;
integer bad_count = 0;
integer checks_done = 0;
qpmii_port dut (.clk, .reset, .ce, .speed_100, .adv_txclk_mode(adv), .tx_clk, .tx_data, .tx_en, .tx_er,
    .line_valid, .line_ready, .line_data, .line_tx_on, .line_halt, .rx_sym_valid, .rx_sym_data, .rx_sym_bad,
    .pll_locked, .rx_clk, .rx_data, .rx_dv, .rx_er);
qpmii_mac mac (.clk, .reset, .tx_clk, .adv, .n_data, .n_en, .n_er, .tx_data, .tx_en, .tx_er);
initial
begin
    clk = 1'h0;
    forever #5 clk = ~clk;
end
////////////////////////////////////////////////////////////////
task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
        bad_count = bad_count + 1;
        $display("Error %s expected %h seen %h", nm, exp, got);
    end
end
endtask
task end_of_test;
begin
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
end
endtask
task tk;
begin
    @(posedge clk);
    #1;
end
endtask
// Returns just after the chosen clock output has moved to level v
task wclk(input logic use_rx, input logic v);
begin
    while ((use_rx ? rx_clk : tx_clk) === v)
        tk;
    while ((use_rx ? rx_clk : tx_clk) !== v)
        tk;
end
endtask
////////////////////////////////////////////////////////////////
task sc_period(input logic [7:0] exp);
    time t0;
begin
    wclk(1'h0, 1'h1);
    t0 = $time;
    wclk(1'h0, 1'h1);
    chk("tx_clk period", 8'(($time - t0) / 10), exp);
    wclk(1'h1, 1'h1);
    t0 = $time;
    wclk(1'h1, 1'h1);
    chk("rx_clk period", 8'(($time - t0) / 10), exp);
end
endtask
task tx(input logic [3:0] d, input logic e, input logic r);
begin
    @(posedge clk);
    n_data <= d;
    n_en <= e;
    n_er <= r;
    wclk(1'h0, adv);
    wclk(1'h0, ~adv);
    repeat (2) tk;
    while (line_valid !== 1'h1)
        tk;
    chk("line_data", line_data, r ? 4'h0 : (e ? d : 4'h0));
    chk("line_tx_on", line_tx_on, e);
    chk("line_halt", line_halt, r);
end
endtask
task sc_tx_words;
begin
    tx(4'ha, 1'h1, 1'h0);
    tx(4'h5, 1'h1, 1'h1);
    tx(4'h3, 1'h0, 1'h1);
    tx(4'hc, 1'h0, 1'h0);
    tx(4'hf, 1'h1, 1'h0);
end
endtask
task rx(input logic [3:0] d, input logic b, input logic lk);
begin
    @(posedge clk);
    pll_locked <= lk;
    wclk(1'h1, 1'h0);
    @(posedge clk);
    rx_sym_valid <= 1'h1;
    rx_sym_data <= d;
    rx_sym_bad <= b;
    @(posedge clk);
    rx_sym_valid <= 1'h0;
    rx_sym_data <= ~d;
    wclk(1'h1, 1'h0);
    chk("rx_data", rx_data, d);
    chk("rx_dv", rx_dv, !b);
    chk("rx_er", rx_er, b | !lk);
    wclk(1'h1, 1'h0);
    chk("rx_dv idle", rx_dv, 1'h0);
    chk("rx_data kept", rx_data, d);
end
endtask
task sc_rx;
begin
    rx(4'h9, 1'h0, 1'h1);
    rx(4'h6, 1'h1, 1'h1);
    rx(4'h3, 1'h0, 1'h0);
end
endtask
task sc_stall;
    integer n;
    logic v;
begin
    @(posedge clk);
    line_ready <= 1'h0;
    repeat (100) tk;
    v = tx_clk;
    n = 0;
    repeat (40)
    begin
        tk;
        n = n + (tx_clk !== v);
    end
    chk("tx_clk held", n, 0);
    @(posedge clk);
    line_ready <= 1'h1;
    n = 0;
    repeat (16)
    begin
        tk;
        n = n + line_valid;
    end
    chk("drained", n >= 7, 1);
end
endtask
////////////////////////////////////////////////////////////////
initial
begin
    reset = 1'h1;
    ce = 1'h1;
    speed_100 = 1'h1;
    adv = 1'h0;
    line_ready = 1'h1;
    rx_sym_valid = 1'h0;
    rx_sym_data = 4'h0;
    rx_sym_bad = 1'h0;
    pll_locked = 1'h1;
    n_data = 4'h0;
    n_en = 1'h0;
    n_er = 1'h0;
    repeat (5) tk;
    chk("reset outputs", {tx_clk, rx_clk, line_valid, line_tx_on, line_halt, rx_dv, rx_er}, 8'h00);
    @(posedge clk);
    reset <= 1'h0;
    repeat (20) tk;
    sc_period(8'h04);
    sc_tx_words;
    sc_rx;
    sc_stall;
    @(posedge clk);
    speed_100 <= 1'h0;
    repeat (60) tk;
    sc_period(8'h28);
    sc_tx_words;
    sc_rx;
    @(posedge clk);
    adv <= 1'h1;
    repeat (60) tk;
    sc_tx_words;
    end_of_test;
end
// Limit sized well above the roughly 1500 cycles the sequence needs
initial
begin
    #400000;
    bad_count = bad_count + 1;
    end_of_test;
end
endmodule

// ==== sim/qpmii_port_monitor.sv ====
// Assertion checker for one MII data port.
// Assumes ce stays high and the speed pin only goes from fast to slow.
`timescale 1ns/1ps
module qpmii_mon
(
    input wire clk,
    input wire reset,
    input wire speed_100,
    input wire line_valid,
    input wire line_ready,
    input wire [3:0] line_data,
    input wire line_tx_on,
    input wire line_halt,
    input wire rx_sym_valid,
    input wire rx_sym_bad,
    input wire pll_locked,
    input wire rx_clk,
    input wire [3:0] rx_data,
    input wire rx_dv,
    input wire rx_er
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
////////////////////////////////////////////////////////////////
chk_fast_rx_half: assert property ($changed(rx_clk) && speed_100 && $past(speed_100, 8)
    |=> $stable(rx_clk) ##1 $changed(rx_clk)) else $error("fast receive clock half period wrong");
chk_slow_rx_half: assert property ($changed(rx_clk) && !speed_100 && !$past(speed_100, 8)
    |=> $stable(rx_clk)[*8] ##12 $changed(rx_clk)) else $error("slow receive clock half period wrong");
chk_rx_on_fall: assert property ($changed({rx_data, rx_dv, rx_er}) |-> $fell(rx_clk))
    else $error("receive outputs moved off the clock fall");
chk_rx_unlock_err: assert property ($fell(rx_clk) && !$past(pll_locked) && !$past(pll_locked, 2) |-> rx_er)
    else $error("receive error missing while unlocked");
chk_rx_good_sym: assert property (rx_sym_valid && !rx_sym_bad && speed_100 && $past(speed_100, 8)
    |-> ##[1:6] ($fell(rx_clk) && rx_dv)) else $error("good symbol not shown as valid");
chk_halt_no_data: assert property (line_valid && line_halt |-> line_data == 4'h0)
    else $error("halt word carries data");
chk_idle_no_data: assert property (line_valid && !line_tx_on && !line_halt |-> line_data == 4'h0)
    else $error("idle word carries data");
chk_line_word_hold: assert property (line_valid && !line_ready
    |=> line_valid && $stable({line_data, line_tx_on, line_halt})) else $error("line word not held");
endmodule
bind qpmii_port qpmii_mon mon (.clk, .reset, .speed_100, .line_valid, .line_ready, .line_data, .line_tx_on,
    .line_halt, .rx_sym_valid, .rx_sym_bad, .pll_locked, .rx_clk, .rx_data, .rx_dv, .rx_er);

// ==== src/qpmii_fifo.v ====
// Flip-flop FIFO with valid/ready on both sides and a fill level.
// Assumes a single clock; ce freezes everything.
`timescale 1ns/1ps
module qpmii_fifo
#(
    parameter W = 6,
    parameter DEPTH = 8,
    parameter AW = 3
)
(
    clk,
    reset,
    ce,
    in_valid,
    in_ready,
    in_data,
    out_valid,
    out_ready,
    out_data,
    level
);
input wire clk;
input wire reset;
input wire ce;
input wire in_valid;
output wire in_ready;
input wire [W-1:0] in_data;
output wire out_valid;
input wire out_ready;
output wire [W-1:0] out_data;
output wire [AW:0] level;

reg [W-1:0] mem_q [0:DEPTH-1];
reg [AW:0] wr_q;
reg [AW:0] rd_q;
wire push;
wire pop;

assign level = wr_q - rd_q;
assign in_ready = (level != DEPTH[AW:0]);
assign out_valid = (wr_q != rd_q);
assign out_data = mem_q[rd_q[AW-1:0]];
assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;

always @(posedge clk)
begin
    if (reset)
    begin
        wr_q <= {(AW+1){1'b0}};
        rd_q <= {(AW+1){1'b0}};
    end
    else if (ce)
    begin
        if (push)
        begin
            mem_q[wr_q[AW-1:0]] <= in_data;
            wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
        end
        if (pop)
            rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
    end
end

endmodule

// ==== src/qpmii_port.v ====
// One MII data port: transmit/receive clock generation, transmit capture
// on the chosen clock edge, word buffering toward the line coder, and
// receive nibble presentation with valid and error flags.
// Assumes the MAC pins are asynchronous to clk and the line-side
// coder and decoder run on clk.
//
// Contract
// - Transmitter is enabled only while transmit enable is high.
// - Transmit clock is 25 MHz at 100 Mbps, 2.5 MHz at 10 Mbps.
// - By default transmit inputs are captured at the rising transmit clock edge.
// - Advanced mode captures transmit inputs at the falling edge instead.
// - While transmit error is high, the Halt code group replaces data.
// - Port accepts a 4-bit NRZ transmit nibble and sends it out.
// - Received data goes to the MAC as nibbles synchronous to receive clock.
// - Receive clock is 25 MHz at 100 Mbps, 2.5 MHz at 10 Mbps.
// - Receive data valid is high while the code group maps to data.
// - Receive error is high for invalid code group or unlocked PLL.
`timescale 1ns/1ps
`include "qpmii_map.vh"
module qpmii_port
#(
    parameter DEPTH = `QPMII_FIFO_DEPTH,
    parameter AW = `QPMII_FIFO_AW
)
(
    clk,
    reset,
    ce,
    speed_100,
    adv_txclk_mode,
    tx_clk,
    tx_data,
    tx_en,
    tx_er,
    line_valid,
    line_ready,
    line_data,
    line_tx_on,
    line_halt,
    rx_sym_valid,
    rx_sym_data,
    rx_sym_bad,
    pll_locked,
    rx_clk,
    rx_data,
    rx_dv,
    rx_er
);
input wire clk;
input wire reset;
input wire ce;
input wire speed_100;
input wire adv_txclk_mode;
output reg tx_clk;
input wire [3:0] tx_data;
input wire tx_en;
input wire tx_er;
output reg line_valid;
input wire line_ready;
output reg [3:0] line_data;
output reg line_tx_on;
output reg line_halt;
input wire rx_sym_valid;
input wire [3:0] rx_sym_data;
input wire rx_sym_bad;
input wire pll_locked;
output reg rx_clk;
output reg [3:0] rx_data;
output reg rx_dv;
output reg rx_er;

// Integer forms are cut to the counter widths on purpose
localparam integer FAST_HALF_INT = `QPMII_FAST_HALF_CYC - 1;
localparam integer SLOW_HALF_INT = `QPMII_SLOW_HALF_CYC - 1;
localparam integer STALL_INT = DEPTH - 1;
localparam [4:0] FAST_HALF_M1 = FAST_HALF_INT[4:0];
localparam [4:0] SLOW_HALF_M1 = SLOW_HALF_INT[4:0];
localparam [AW:0] STALL_LEVEL = STALL_INT[AW:0];
localparam W = `QPMII_WORD_W;

////////////////////////////////////////////////////////////////////////
// Pin synchronisers for MAC-side and strap-like inputs

wire [3:0] txd_s;
wire txen_s;
wire txer_s;
wire spd_s;
wire adv_s;

qpmii_sync #(.W(6), .INIT(6'h00)) u_sync_tx
(
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .din({tx_er, tx_en, tx_data}),
    .dout({txer_s, txen_s, txd_s})
);

// Mode pins may change at any time, so they are filtered like the MAC pins
qpmii_sync #(.W(2), .INIT(2'h0)) u_sync_cfg
(
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .din({adv_txclk_mode, speed_100}),
    .dout({adv_s, spd_s})
);

// Limitation: a speed change lands mid-period, so one half may come out short
wire [4:0] half_m1;
assign half_m1 = spd_s ? FAST_HALF_M1 : SLOW_HALF_M1;

////////////////////////////////////////////////////////////////////////
// Transmit clock divider; stretched while the buffer is nearly full

wire fifo_in_ready;
wire [AW:0] fifo_level;
wire tx_run;
wire tx_wrap;
wire tx_rise;
wire tx_fall;
wire sample_evt;
reg [4:0] tx_cnt_q;
reg [`QPMII_CAP_DELAY-1:0] cap_pipe_q;

// Holding the clock is the only back-pressure a MAC understands
assign tx_run = fifo_in_ready & (fifo_level < STALL_LEVEL);
assign tx_wrap = tx_run & (tx_cnt_q >= half_m1);
assign tx_rise = tx_wrap & ~tx_clk;
assign tx_fall = tx_wrap & tx_clk;
assign sample_evt = adv_s ? tx_fall : tx_rise;

always @(posedge clk)
begin
    if (reset)
    begin
        tx_cnt_q <= 5'h00;
        tx_clk <= 1'b0;
        cap_pipe_q <= {`QPMII_CAP_DELAY{1'b0}};
    end
    else if (ce)
    begin
        if (tx_wrap)
        begin
            tx_cnt_q <= 5'h00;
            tx_clk <= ~tx_clk;
        end
        else if (tx_run)
            tx_cnt_q <= tx_cnt_q + 5'h01;
        // Delay the sampling point by the full synchroniser latency: three
        // flops plus the agreement stage, so the word read is the one sampled
        cap_pipe_q <= {cap_pipe_q[`QPMII_CAP_DELAY-2:0], sample_evt};
    end
end

////////////////////////////////////////////////////////////////////////
// Transmit word build: halt, data or idle

wire capture;
reg [W-1:0] tx_word;

assign capture = cap_pipe_q[`QPMII_CAP_DELAY-1];

// Halt keeps the enable bit so the coder knows the frame is still open
always @*
begin
    tx_word = {W{1'b0}};
    if (txer_s)
    begin
        tx_word[`QPMII_F_ER] = 1'b1;
        tx_word[`QPMII_F_EN] = txen_s;
    end
    else if (txen_s)
    begin
        tx_word[`QPMII_F_EN] = 1'b1;
        tx_word[`QPMII_F_DATA_MSB:`QPMII_F_DATA_LSB] = txd_s;
    end
    else
        tx_word[`QPMII_F_DATA_MSB:`QPMII_F_DATA_LSB] = `QPMII_IDLE_NIBBLE;
end

////////////////////////////////////////////////////////////////////////
// Buffer between MAC capture and the line coder

wire fifo_out_valid;
wire fifo_out_ready;
wire [W-1:0] fifo_out_data;

qpmii_fifo #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_fifo
(
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .in_valid(capture),
    .in_ready(fifo_in_ready),
    .in_data(tx_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
);

// A new word loads only once the coder has taken the last one
assign fifo_out_ready = ~line_valid | line_ready;

always @(posedge clk)
begin
    if (reset)
    begin
        line_valid <= 1'b0;
        line_data <= `QPMII_IDLE_NIBBLE;
        line_tx_on <= 1'b0;
        line_halt <= 1'b0;
    end
    else if (ce)
    begin
        if (fifo_out_ready)
        begin
            line_valid <= fifo_out_valid;
            if (fifo_out_valid)
            begin
                line_data <= fifo_out_data[`QPMII_F_DATA_MSB:`QPMII_F_DATA_LSB];
                line_tx_on <= fifo_out_data[`QPMII_F_EN];
                line_halt <= fifo_out_data[`QPMII_F_ER];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Receive clock divider

// Free running: the MAC has no way to push back on receive
reg [4:0] rx_cnt_q;
wire rx_wrap;
wire rx_fall;

assign rx_wrap = (rx_cnt_q >= half_m1);
assign rx_fall = rx_wrap & rx_clk;

always @(posedge clk)
begin
    if (reset)
    begin
        rx_cnt_q <= 5'h00;
        rx_clk <= 1'b0;
    end
    else if (ce)
    begin
        if (rx_wrap)
        begin
            rx_cnt_q <= 5'h00;
            rx_clk <= ~rx_clk;
        end
        else
            rx_cnt_q <= rx_cnt_q + 5'h01;
    end
end

////////////////////////////////////////////////////////////////////////
// Receive hold and presentation on the falling receive clock edge

// The hold register bridges the decoder's one-cycle pulse to the slower clock
reg hold_v_q;
reg hold_bad_q;
reg [3:0] hold_d_q;

// Outputs change at the falling edge so they are steady at the MAC's rising edge
always @(posedge clk)
begin
    if (reset)
    begin
        hold_v_q <= 1'b0;
        hold_bad_q <= 1'b0;
        hold_d_q <= `QPMII_RESET_NIBBLE;
        rx_data <= `QPMII_RESET_NIBBLE;
        rx_dv <= 1'b0;
        rx_er <= 1'b0;
    end
    else if (ce)
    begin
        if (rx_fall)
        begin
            rx_data <= hold_d_q;
            rx_dv <= hold_v_q & ~hold_bad_q;
            rx_er <= (hold_v_q & hold_bad_q) | ~pll_locked;
        end
        // A new symbol landing with the clear wins over it
        if (rx_sym_valid)
        begin
            hold_v_q <= 1'b1;
            hold_bad_q <= rx_sym_bad;
            hold_d_q <= rx_sym_data;
        end
        else if (rx_fall)
            hold_v_q <= 1'b0;
    end
end

endmodule

// ==== src/qpmii_sync.v ====
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module qpmii_sync
#(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
)
(
    clk,
    reset,
    ce,
    din,
    dout
);
input wire clk;
input wire reset;
input wire ce;
input wire [W-1:0] din;
output reg [W-1:0] dout;

reg [W-1:0] s1_q;
reg [W-1:0] s2_q;
reg [W-1:0] s3_q;

// Stage one feeds only stage two, so metastability never reaches logic
always @(posedge clk)
begin
    if (reset)
    begin
        s1_q <= INIT;
        s2_q <= INIT;
        s3_q <= INIT;
        dout <= INIT;
    end
    else if (ce)
    begin
        s1_q <= din;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q)
            dout <= s3_q;
    end
end

endmodule
